// *** fbcps_chk.sv ***
// Port assertions for the four-bit core datapath.
`timescale 1ns/10ps
`include "fbcps_regs.vh"
module fbcps_chk (
  input wire       clock,
  input wire       resetn,
  input wire       exec_en,
  input wire [3:0] op_code,
  input wire [4:0] op_imm,
  input wire [9:0] op_target,
  input wire [1:0] carry_op,
  input wire [9:0] pc_r,
  input wire [3:0] acc_r,
  input wire       carry_r,
  input wire [1:0] row_ptr_r,
  input wire [3:0] col_ptr_r,
  input wire       skip_r
);
  // An op acts only when the one before it asked for no skip.
  wire go = exec_en && !skip_r;
  wire cbit = carry_op[0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_rst; disable iff (1'b0) !resetn |=> pc_r == 10'h000; endproperty
  a_rst: assert property (p_rst) else $error("pc not cleared");
  property p_nop; go && op_code == `FBCPS_OP_NOP |=> pc_r == (($past(pc_r) == `FBCPS_ROM_LAST) ?
    10'h000 : $past(pc_r) + 10'h001); endproperty
  a_nop: assert property (p_nop) else $error("pc step wrong");
  property p_jmp; go && op_code == `FBCPS_OP_JUMP |=> pc_r == $past(op_target); endproperty
  a_jmp: assert property (p_jmp) else $error("jump target wrong");
  property p_pair; go && op_code == `FBCPS_OP_LD_PAIR |=>
    {row_ptr_r, col_ptr_r} == {1'b0, $past(op_imm)}; endproperty
  a_pair: assert property (p_pair) else $error("pair load wrong");
  property p_inc; go && op_code == `FBCPS_OP_LD_INC |=> col_ptr_r == $past(col_ptr_r) + 4'h1
    && skip_r == ($past(col_ptr_r) == 4'hf); endproperty
  a_inc: assert property (p_inc) else $error("step up wrong");
  property p_dec; go && op_code == `FBCPS_OP_LD_DEC |=> col_ptr_r == $past(col_ptr_r) - 4'h1
    && skip_r == ($past(col_ptr_r) == 4'h0); endproperty
  a_dec: assert property (p_dec) else $error("step down wrong");
  property p_skp; exec_en && skip_r |=> !skip_r && $stable(acc_r) && $stable(col_ptr_r);
  endproperty
  a_skp: assert property (p_skp) else $error("skipped op acted");
  property p_cset; go && op_code == `FBCPS_OP_CARRY && !carry_op[1] |=> carry_r == $past(cbit);
  endproperty
  a_cset: assert property (p_cset) else $error("carry set wrong");
endmodule // fbcps_chk
bind fbcps_core fbcps_chk u_chk (.*);

// *** fbcps_core.v ***
// Datapath of the four-bit core: ALU, accumulator, carry, pointer pair, RAM, PC and stack.
`timescale 1ns/10ps
`include "fbcps_regs.vh"

// Overview of operation
// - Two-bit row and four-bit column pointer registers.
// - Row picks RAM row, column picks column.
// - Pointer halves separately accessible; column steps.
// - RAM holds 48 words, three by sixteen.
// - Display latch reads RAM through its own port.
// - Program store is 768 eight-bit bytes.
// - Fetch runs linearly across page boundaries.
// - Ten-bit PC holds current instruction address.
// - PC increments, loads on jump or call.
// - Call pushes return address, return pops it.
// - Return stack has two ten-bit entries.
// - Carry set, cleared, tested; set by add.
// - Accumulator takes results and transfers data.
// - Load-inc/dec step column; skip on wrap.
// - Pair load writes five immediate bits at once.
module fbcps_core (
  input  wire        clock,
  input  wire        resetn,
  input  wire        exec_en,
  input  wire [3:0]  op_code,
  input  wire [4:0]  op_imm,
  input  wire [9:0]  op_target,
  input  wire [1:0]  carry_op,
  input  wire [3:0]  port_in,
  input  wire        rom_wr_en,
  input  wire [9:0]  rom_wr_addr,
  input  wire [7:0]  rom_wr_data,
  input  wire [1:0]  disp_row,
  input  wire [3:0]  disp_col,
  output reg  [9:0]  pc_r,
  output reg  [7:0]  instr_r,
  output reg  [3:0]  acc_r,
  output reg         carry_r,
  output reg         carry_test_r,
  output reg  [1:0]  row_ptr_r,
  output reg  [3:0]  col_ptr_r,
  output reg         skip_r,
  output reg  [3:0]  port_out_r,
  output reg  [3:0]  disp_data_r
);

  // Storage: program array, data RAM and two-deep return stack.
  // All three are plain flip-flop arrays. The RAM and the program store carry no
  // reset, so software must write a location before it reads it back.
  reg  [7:0] rom_mem [0:`FBCPS_ROM_DEPTH-1];
  reg  [3:0] ram_mem [0:`FBCPS_RAM_ROWS*`FBCPS_RAM_COLS-1];
  reg  [9:0] stack_top_r;
  reg  [9:0] stack_low_r;
  reg        skip_nxt;
  reg  [9:0] pc_nxt;
  // Combinational helpers that feed the sequencer below.
  reg  [4:0] sum;
  wire [5:0] ptr_idx;
  wire [9:0] pc_step;
  wire [3:0] ram_rd;

  // Flat RAM index; rows 3 and above fold onto row 2 so no access leaves the array.
  // The fold costs some aliasing but avoids an out-of-range array read.
  function [5:0] fbcps_index;
    input [1:0] row;
    input [3:0] col;
    begin
      fbcps_index = {(row == 2'b11) ? 2'b10 : row, col};
    end
  endfunction

  // Column pointer step. The four-bit add and subtract wrap on purpose,
  // because the skip test relies on seeing the wrap to zero or to fifteen.
  function [3:0] fbcps_col_step;
    input [3:0] col;
    input       down;
    begin
      fbcps_col_step = down ? col - 4'h1 : col + 4'h1;
    end
  endfunction

  // Linear increment, wrapping past the last program byte back to zero.
  // No page or field limit applies, so the step is a plain ten-bit add.
  // A jump target above the last byte is not trapped here.
  function [9:0] fbcps_pc_inc;
    input [9:0] pc;
    begin
      fbcps_pc_inc = (pc == `FBCPS_ROM_LAST) ? `FBCPS_PC_RESET : pc + 10'h001;
    end
  endfunction

  assign ptr_idx = fbcps_index(row_ptr_r, col_ptr_r);
  assign pc_step = fbcps_pc_inc(pc_r);
  assign ram_rd  = ram_mem[ptr_idx];

  // Next program counter: a skipped slot takes the single step, transfers load the target.
  // A skipped slot still costs one full cycle, so a skip never lets the
  // following instruction run early; only the PC moves in that slot.
  always @* begin
    sum     = {1'b0, acc_r} + {1'b0, ram_rd};
    skip_nxt = 1'b0;
    pc_nxt  = pc_step;
    if (skip_r) begin
      pc_nxt = pc_step;
    end else begin
      case (op_code)
        `FBCPS_OP_LD_INC: begin
          skip_nxt = fbcps_col_step(col_ptr_r, 1'b0) == `FBCPS_COL_ZERO;
        end
        `FBCPS_OP_LD_DEC: begin
          skip_nxt = fbcps_col_step(col_ptr_r, 1'b1) == `FBCPS_COL_TOP;
        end
        `FBCPS_OP_JUMP:   pc_nxt = op_target;
        `FBCPS_OP_CALL:   pc_nxt = op_target;
        `FBCPS_OP_RET:    pc_nxt = stack_top_r;
        default:          pc_nxt = pc_step;
      endcase
    end
  end

  // Program loading port; storage has no reset, as mask contents would not.
  // Writes beyond the last byte are dropped rather than aliased.
  always @(posedge clock) begin
    if (rom_wr_en && rom_wr_addr <= `FBCPS_ROM_LAST) begin
      rom_mem[rom_wr_addr] <= rom_wr_data;
    end
  end

  // Display fetch runs every cycle, independent of instruction execution.
  // It has its own read port, so the display never stalls the program.
  always @(posedge clock) begin
    if (!resetn) begin
      disp_data_r <= 4'h0;
    end else begin
      disp_data_r <= ram_mem[fbcps_index(disp_row, disp_col)];
    end
  end

  // RAM writes through the pointer pair.
  // A skipped store must not land, hence the skip term in the enable.
  always @(posedge clock) begin
    if (resetn && exec_en && !skip_r && op_code == `FBCPS_OP_ST_MEM) begin
      ram_mem[ptr_idx] <= acc_r;
    end
  end

  // Sequencer and datapath; a skipped instruction only advances the PC.
  // Everything is held while exec_en is low, which lets the program port
  // be filled without disturbing the machine state.
  always @(posedge clock) begin
    if (!resetn) begin
      pc_r         <= `FBCPS_PC_RESET;
      instr_r      <= 8'h00;
      acc_r        <= 4'h0;
      carry_r      <= 1'b0;
      carry_test_r <= 1'b0;
      row_ptr_r    <= 2'b00;
      col_ptr_r    <= 4'h0;
      skip_r       <= 1'b0;
      port_out_r   <= 4'h0;
      stack_top_r  <= 10'h000;
      stack_low_r  <= 10'h000;
    end else if (exec_en) begin
      pc_r    <= pc_nxt;
      instr_r <= rom_mem[pc_nxt];
      skip_r  <= skip_nxt;
      if (!skip_r) begin
        case (op_code)
          `FBCPS_OP_LDA_IMM: acc_r <= op_imm[3:0];
          `FBCPS_OP_LD_MEM:  acc_r <= ram_rd;
          // The load uses the old pointer; the step shows from the next cycle.
          `FBCPS_OP_LD_INC: begin
            acc_r     <= ram_rd;
            col_ptr_r <= fbcps_col_step(col_ptr_r, 1'b0);
          end
          `FBCPS_OP_LD_DEC: begin
            acc_r     <= ram_rd;
            col_ptr_r <= fbcps_col_step(col_ptr_r, 1'b1);
          end
          // Only five immediate bits exist, so the upper row bit of a pair load is zero.
          `FBCPS_OP_LD_PAIR: begin
            row_ptr_r <= {1'b0, op_imm[4]};
            col_ptr_r <= op_imm[3:0];
          end
          `FBCPS_OP_ROW_WR: row_ptr_r <= acc_r[1:0];
          `FBCPS_OP_COL_WR: col_ptr_r <= acc_r;
          `FBCPS_OP_ROW_RD: acc_r <= {2'b00, row_ptr_r};
          `FBCPS_OP_COL_RD: acc_r <= col_ptr_r;
          `FBCPS_OP_ADD: begin
            acc_r   <= sum[3:0];
            carry_r <= sum[4] ? 1'b1 : carry_r;
          end
          // The carry group shares one code; carry_op picks clear, set, test
          // or the port exchange through the accumulator.
          `FBCPS_OP_CARRY: begin
            case (carry_op)
              2'b00:   carry_r <= 1'b0;
              2'b01:   carry_r <= 1'b1;
              2'b10:   carry_test_r <= carry_r;
              default: port_out_r <= acc_r;
            endcase
            if (carry_op == 2'b11) begin
              acc_r <= port_in;
            end
          end
          // A push moves the top entry down, so a third call silently drops
          // the oldest return address; no overflow flag is kept.
          `FBCPS_OP_CALL: begin
            stack_low_r <= stack_top_r;
            stack_top_r <= pc_step;
          end
          // A pop leaves the lower entry in place; returning past an empty
          // stack yields the older value again.
          `FBCPS_OP_RET: stack_top_r <= stack_low_r;
          default: acc_r <= acc_r;
        endcase
      end
    end
  end

endmodule // fbcps_core

// *** fbcps_regs.vh ***
// Constants for the four-bit core datapath, pointer pair and return stack.
`ifndef FBCPS_REGS_VH
`define FBCPS_REGS_VH
`define FBCPS_ROM_DEPTH   768
`define FBCPS_ROM_LAST    10'h2ff
`define FBCPS_RAM_ROWS    3
`define FBCPS_RAM_COLS    16
`define FBCPS_PC_RESET    10'h000
`define FBCPS_COL_ZERO    4'h0
`define FBCPS_COL_TOP     4'hf
`define FBCPS_OP_NOP      4'h0
`define FBCPS_OP_LDA_IMM  4'h1
`define FBCPS_OP_LD_MEM   4'h2
`define FBCPS_OP_LD_INC   4'h3
`define FBCPS_OP_LD_DEC   4'h4
`define FBCPS_OP_ST_MEM   4'h5
`define FBCPS_OP_LD_PAIR  4'h6
`define FBCPS_OP_ROW_WR   4'h7
`define FBCPS_OP_COL_WR   4'h8
`define FBCPS_OP_ROW_RD   4'h9
`define FBCPS_OP_COL_RD   4'ha
`define FBCPS_OP_ADD      4'hb
`define FBCPS_OP_CARRY    4'hc
`define FBCPS_OP_JUMP     4'hd
`define FBCPS_OP_CALL     4'he
`define FBCPS_OP_RET      4'hf
`endif

// *** tb_top.sv ***
// Self-checking bench for the four-bit core datapath.
`timescale 1ns/10ps
`include "fbcps_regs.vh"
module tb_top;
  reg clock = 1'b0, resetn = 1'b0, exec_en = 1'b0, rom_wr_en = 1'b0;
  reg [3:0] op_code = 4'h0, port_in = 4'h0, disp_col = 4'h0;
  reg [9:0] op_target = 10'h000, rom_wr_addr = 10'h100, pc0;
  reg [7:0] rom_wr_data = 8'h5a;
  reg [1:0] disp_row = 2'h0;
  wire [4:0] op_imm = op_target[4:0];
  wire [1:0] carry_op = op_target[1:0], row_ptr_r;
  wire [9:0] pc_r;
  wire [7:0] instr_r;
  wire [3:0] acc_r, port_out_r, disp_data_r, col_ptr_r;
  wire carry_r, carry_test_r, skip_r;
  integer error_cnt = 0, total_checks = 0, cycles = 0, i, k;
  fbcps_core dut (
    .clock        (clock),
    .resetn       (resetn),
    .exec_en      (exec_en),
    .op_code      (op_code),
    .op_imm       (op_imm),
    .op_target    (op_target),
    .carry_op     (carry_op),
    .port_in      (port_in),
    .rom_wr_en    (rom_wr_en),
    .rom_wr_addr  (rom_wr_addr),
    .rom_wr_data  (rom_wr_data),
    .disp_row     (disp_row),
    .disp_col     (disp_col),
    .pc_r         (pc_r),
    .instr_r      (instr_r),
    .acc_r        (acc_r),
    .carry_r      (carry_r),
    .carry_test_r (carry_test_r),
    .row_ptr_r    (row_ptr_r),
    .col_ptr_r    (col_ptr_r),
    .skip_r       (skip_r),
    .port_out_r   (port_out_r),
    .disp_data_r  (disp_data_r)
  );
  // Free-running clock; the counter cuts a hang short.
  initial begin forever #5 clock = ~clock; end
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  end
  task chk(input [8*5:1] n, input [31:0] s, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("Error %0s exp %h seen %h", n, e, s);
      end
    end
  endtask
  // Inputs move a step after the edge, so each op is taken at the next edge.
  task op(input [3:0] c, input [9:0] v);
    begin
      op_code = c;
      op_target = v;
      exec_en = 1'b1;
      @(posedge clock);
      #1;
    end
  endtask
  task t_ram;
    for (i = 0; i < 12; i = i + 1) begin
      k = i % 6;
      disp_row = k % 3;
      disp_col = k * 5 % 16;
      op(`FBCPS_OP_LDA_IMM, k % 3);
      op(`FBCPS_OP_ROW_WR, 0);
      op(`FBCPS_OP_LDA_IMM, k * 5 % 16);
      op(`FBCPS_OP_COL_WR, 0);
      chk("col", col_ptr_r, k * 5 % 16);
      op(i < 6 ? `FBCPS_OP_LDA_IMM : `FBCPS_OP_LD_MEM, k + 3);
      if (i < 6) op(`FBCPS_OP_ST_MEM, 0);
      else begin
        chk("ram", acc_r, k + 3);
        chk("disp", disp_data_r, k + 3);
        op(`FBCPS_OP_ROW_RD, 0);
        chk("row", acc_r, k % 3);
      end
    end
  endtask
  task t_skip;
    begin
      op(`FBCPS_OP_LD_PAIR, 10'h00f);
      op(`FBCPS_OP_LD_INC, 0);
      chk("inc", {skip_r, col_ptr_r, acc_r}, 9'h106);
      pc0 = pc_r;
      op(`FBCPS_OP_LDA_IMM, 10'h009);
      chk("skip", {pc_r, acc_r, skip_r}, {pc0 + 10'h001, 5'h0c});
      op(`FBCPS_OP_LD_DEC, 0);
      chk("dec", {skip_r, col_ptr_r, acc_r}, 9'h1f3);
      op(`FBCPS_OP_NOP, 0);
      op(`FBCPS_OP_LD_PAIR, 10'h01f);
      chk("pair", {row_ptr_r, col_ptr_r}, 6'h1f);
    end
  endtask
  task t_carry;
    begin
      port_in = 4'h6;
      op(`FBCPS_OP_CARRY, 1);
      op(`FBCPS_OP_CARRY, 2);
      chk("cset", {carry_r, carry_test_r}, 2'b11);
      op(`FBCPS_OP_CARRY, 0);
      op(`FBCPS_OP_CARRY, 2);
      chk("cclr", {carry_r, carry_test_r}, 2'b00);
      op(`FBCPS_OP_LDA_IMM, 5);
      op(`FBCPS_OP_CARRY, 3);
      chk("swap", {port_out_r, acc_r}, 8'h56);
      op(`FBCPS_OP_LD_PAIR, 10'h000);
      op(`FBCPS_OP_LDA_IMM, 10'h00e);
      op(`FBCPS_OP_ADD, 0);
      chk("add", {carry_r, acc_r}, 5'h11);
      op(`FBCPS_OP_LDA_IMM, 10'h004);
      op(`FBCPS_OP_ADD, 0);
      chk("addnc", {carry_r, acc_r}, 5'h17);
    end
  endtask
  // The program byte is loaded while execution is held off.
  task t_stack;
    begin
      exec_en = 1'b0;
      rom_wr_en = 1'b1;
      @(posedge clock); #1;
      rom_wr_en = 1'b0;
      op(`FBCPS_OP_CALL, 10'h100);
      chk("call", {pc_r, instr_r}, 18'h1005a);
      op(`FBCPS_OP_CALL, 10'h200);
      op(`FBCPS_OP_CALL, 10'h2fe);
      op(`FBCPS_OP_NOP, 0);
      op(`FBCPS_OP_NOP, 0);
      chk("wrap", pc_r, 10'h000);
      op(`FBCPS_OP_RET, 0);
      chk("ret1", pc_r, 10'h201);
      op(`FBCPS_OP_RET, 0);
      chk("ret2", pc_r, 10'h101);
      op(`FBCPS_OP_JUMP, 10'h2a5);
      chk("jump", pc_r, 10'h2a5);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clock);
    #1;
    chk("rst", {pc_r, acc_r, skip_r}, 15'h0000);
    resetn = 1'b1;
    t_ram;
    t_skip;
    t_carry;
    t_stack;
    summarize;
  end
endmodule // tb_top
